// ==== inc/hbi_pkg.sv ====
`default_nettype none
package hbi_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 40;
    // Internal processing time of one byte
    localparam int PROC_NS = 640;
    localparam int PROC_CYC = (PROC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] PROC_LD = 4'(PROC_CYC - 1);
    // Half period of the strobe the host makes
    localparam int HALF_NS = 320;
    localparam int HALF_CYC = HALF_NS / CLK_NS;
    localparam logic [3:0] HALF_LD = 4'(HALF_CYC - 1);
    localparam logic [3:0] MID_TMR = 4'(HALF_CYC / 2);

    // ****************************************
    // Byte counter and address
    // ****************************************
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [2:0] LAST_PAR = 3'h1;
    localparam logic [2:0] LAST_SER = 3'h7;
    localparam logic [1:0] ADDR_RST = 2'h0;
    localparam logic [3:0] UNITS_ADR = 4'h1;
    localparam logic [3:0] UNITS_PAR = 4'h2;
    localparam logic [3:0] UNITS_SER = 4'h8;

    // ****************************************
    // Host register map
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam int CTRL_RST_BIT = 0;
    localparam int CTRL_PAR_BIT = 1;
    localparam int CTRL_CAE_BIT = 2;
    localparam int CTRL_SEL_BIT = 3;
    localparam logic [3:0] CTRL_RST_VAL = 4'h1;
    localparam int DATA_ADR_BIT = 8;
    localparam int DATA_RD_BIT = 9;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_BSY_BIT = 1;
    localparam int STAT_RX_LSB = 8;

    // Host sequencer states
    typedef enum logic [3:0] {
        HST_IDLE = 4'b0001,
        HST_WAIT = 4'b0010,
        HST_HIGH = 4'b0100,
        HST_LOW = 4'b1000
    } hbi_hst_e;

endpackage
`default_nettype wire

// ==== inc/hbi_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface hbi_if;
    logic strobe_n;
    logic cs_n;
    logic link_rst;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] d_out;
    logic [3:0] d_oe;
    logic busy_n_o;
    logic busy_oe;
    logic [3:0] nibble_bus;
    logic busy_n;

    // Wire level with pull-ups on idle lines
    assign nibble_bus = (d_oe & d_out) | (~d_oe & h_oe & h_out)
        | (~d_oe & ~h_oe);
    assign busy_n = busy_oe ? busy_n_o : 1'b1;

    modport dev (
        input strobe_n, cs_n, nibble_bus,
        output d_out, d_oe, busy_n_o, busy_oe
    );
    modport host (
        output strobe_n, cs_n, link_rst, h_out, h_oe,
        input nibble_bus, busy_n
    );
endinterface
`default_nettype wire

// ==== hw/hbi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbi_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] meta_ff;

    // Two-stage synchroniser; data only, so no reset
    always_ff @(posedge CLK)
    begin
        meta_ff <= D;
        Q <= meta_ff;
    end
endmodule
`default_nettype wire

// ==== hw/hbi_dev.sv ====
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hbi_dev (
    hbi_if.dev LNK,
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CHIP_ID_BIT1,
    input wire logic CHIP_ID_BIT0,
    input wire logic [7:0] TX_BYTE,
    input wire logic READ_MODE,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic PAR_MODE,
    output logic ADDR_EN
);

    // ****************************************
    // State
    // ****************************************
    // Rising-strobe state cleared while deselected
    typedef struct packed {
        logic [2:0] cnt;
        logic pend;
        logic [7:0] sh;
    } hbi_lc_s;

    // Rising-strobe state that survives deselect
    typedef struct packed {
        logic [7:0] rx;
        logic tgl;
        logic [1:0] aser;
    } hbi_lk_s;

    // Falling-strobe output drive
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] doe;
    } hbi_fd_s;

    // System clock state
    typedef struct packed {
        logic rq;
        logic par;
        logic cae;
        logic [1:0] id;
        logic [7:0] rx;
        logic vld;
        logic busy;
        logic [3:0] pc;
        logic done;
        logic seen;
        logic [7:0] tx;
    } hbi_sys_s;

    hbi_lc_s lc_ff;
    hbi_lc_s nxt_lc;
    hbi_lk_s lk_ff;
    hbi_lk_s nxt_lk;
    hbi_fd_s fd_ff;
    hbi_fd_s nxt_fd;
    hbi_sys_s s_ff;
    hbi_sys_s nxt_s;
    logic [1:0] apar_ff;
    logic [1:0] nxt_apar;
    logic lnk_clr;
    logic sel;
    logic fin;
    logic rd;
    logic [1:0] addr_cur;
    logic [3:0] strap_s;
    logic tgl_s;

    // ****************************************
    // Crossings
    // ****************************************
    // Straps and chip identity pins enter the system clock
    hbi_sync #(.W(4)) u_strap (
        .CLK(CLK),
        .D({LNK.nibble_bus[2], LNK.nibble_bus[1], CHIP_ID_BIT1,
            CHIP_ID_BIT0}),
        .Q(strap_s)
    );

    // Byte-done toggle from the strobe domain
    hbi_sync #(.W(1)) u_tgl (
        .CLK(CLK),
        .D(lk_ff.tgl),
        .Q(tgl_s)
    );

    // ****************************************
    // Selection
    // ****************************************
    // Counter clear: asynchronous, since the strobe may stand still
    assign lnk_clr = LNK.cs_n | SYS_RST;
    assign addr_cur = s_ff.par ? apar_ff : lk_ff.aser;
    // Unaddressed serial mode always counts as selected
    assign sel = (~s_ff.par & ~s_ff.cae) | (addr_cur == s_ff.id);
    assign rd = READ_MODE & sel;

    // ****************************************
    // Rising strobe: input and byte counter
    // ****************************************
    always_comb
    begin
        nxt_lc = lc_ff;
        nxt_lk = lk_ff;
        fin = 1'b0;
        if (s_ff.par)
        begin
            // Address strobe is not part of any byte
            if (lc_ff.pend)
            begin
                nxt_lc.pend = 1'b0;
            end
            else
            begin
                nxt_lc.sh = {lc_ff.sh[3:0], LNK.nibble_bus};
                fin = (lc_ff.cnt == hbi_pkg::LAST_PAR);
                nxt_lc.cnt = fin ? hbi_pkg::CNT_RST
                    : lc_ff.cnt + 3'h1;
            end
        end
        else
        begin
            nxt_lc.sh = {lc_ff.sh[6:0], LNK.nibble_bus[0]};
            nxt_lc.cnt = lc_ff.cnt + 3'h1;
            if (lc_ff.cnt == hbi_pkg::LAST_SER && s_ff.cae && lc_ff.pend)
            begin
                // Seventh and eighth bits name the chip
                nxt_lk.aser = {lc_ff.sh[0], LNK.nibble_bus[0]};
                nxt_lc.pend = 1'b0;
            end
            else
            begin
                fin = (lc_ff.cnt == hbi_pkg::LAST_SER);
            end
        end
        // Completed byte hands over and drops busy at once
        if (fin && sel)
        begin
            nxt_lk.rx = nxt_lc.sh;
            nxt_lk.tgl = ~lk_ff.tgl;
        end
    end

    always_ff @(posedge LNK.strobe_n or posedge lnk_clr)
    begin
        if (lnk_clr)
        begin
            lc_ff <= '{cnt: hbi_pkg::CNT_RST, pend: 1'b1, sh: 8'h00};
        end
        else
        begin
            lc_ff <= nxt_lc;
        end
    end

    // Address and toggle survive deselect, cleared only by reset
    always_ff @(posedge LNK.strobe_n or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            lk_ff <= '{rx: 8'h00, tgl: 1'b0, aser: hbi_pkg::ADDR_RST};
        end
        else
        begin
            lk_ff <= nxt_lk;
        end
    end

    // ****************************************
    // Falling strobe: address and output drive
    // ****************************************
    always_comb
    begin
        nxt_apar = apar_ff;
        nxt_fd = fd_ff;
        if (s_ff.par)
        begin
            if (lc_ff.pend)
            begin
                // Only the first falling edge after select
                nxt_apar = LNK.nibble_bus[1:0];
                nxt_fd.doe = 4'h0;
            end
            else
            begin
                nxt_fd.doe = rd ? 4'hF : 4'h0;
                nxt_fd.dout = (lc_ff.cnt == hbi_pkg::CNT_RST)
                    ? s_ff.tx[7:4] : s_ff.tx[3:0];
            end
        end
        else
        begin
            // Serial output rides on the top data line
            nxt_fd.doe = {rd & ~(s_ff.cae & lc_ff.pend), 3'h0};
            nxt_fd.dout = {s_ff.tx[3'h7 - lc_ff.cnt], 3'h0};
        end
    end

    always_ff @(negedge LNK.strobe_n or posedge lnk_clr)
    begin
        if (lnk_clr)
        begin
            fd_ff <= '{dout: 4'h0, doe: 4'h0};
        end
        else
        begin
            fd_ff <= nxt_fd;
        end
    end

    always_ff @(negedge LNK.strobe_n or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            apar_ff <= hbi_pkg::ADDR_RST;
        end
        else
        begin
            apar_ff <= nxt_apar;
        end
    end

    // ****************************************
    // System clock: mode latch and processing
    // ****************************************
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.rq = 1'b0;
        nxt_s.vld = 1'b0;
        // First cycle after reset release catches the straps
        if (s_ff.rq)
        begin
            nxt_s.cae = strap_s[3];
            nxt_s.par = strap_s[2];
            nxt_s.id = strap_s[1:0];
        end
        if (tgl_s != s_ff.seen)
        begin
            nxt_s.seen = tgl_s;
            nxt_s.rx = lk_ff.rx;
            nxt_s.vld = 1'b1;
            nxt_s.busy = 1'b1;
            nxt_s.pc = hbi_pkg::PROC_LD;
        end
        else if (s_ff.busy)
        begin
            if (s_ff.pc == 4'h0)
            begin
                nxt_s.busy = 1'b0;
                nxt_s.done = ~s_ff.done;
                nxt_s.tx = TX_BYTE;
            end
            else
            begin
                nxt_s.pc = s_ff.pc - 4'h1;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            s_ff <= '{rq: 1'b1, par: 1'b0, cae: 1'b0, id: 2'h0,
                rx: 8'h00, vld: 1'b0, busy: 1'b0, pc: 4'h0, done: 1'b0,
                seen: 1'b0, tx: 8'h00};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Busy is low while the two toggles differ; only one moves at once
    assign LNK.busy_n_o = (lk_ff.tgl == s_ff.done);
    assign LNK.busy_oe = ~LNK.cs_n & sel;
    assign LNK.d_out = fd_ff.dout;
    assign LNK.d_oe = fd_ff.doe;
    assign RX_BYTE = s_ff.rx;
    assign RX_VALID = s_ff.vld;
    assign PAR_MODE = s_ff.par;
    assign ADDR_EN = s_ff.cae;
endmodule
`default_nettype wire

// ==== hw/hbi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbi_host (
    hbi_if.host LNK,
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0] ctrl;
        logic [7:0] tbyte;
        logic isadr;
        logic rd;
        hbi_pkg::hbi_hst_e st;
        logic [3:0] tmr;
        logic [3:0] unit;
        logic [3:0] nunit;
        logic [7:0] rx;
        logic strb;
        logic [3:0] hout;
        logic [3:0] hoe;
        logic ap;
        logic [7:0] aofs;
        logic [31:0] rdata;
    } hbi_hst_s;

    hbi_hst_s h_ff;
    hbi_hst_s nxt_h;
    logic [4:0] in_s;
    logic take;
    logic par;

    // Busy and bus come from the other party
    hbi_sync #(.W(5)) u_in (
        .CLK(CLK),
        .D({LNK.busy_n, LNK.nibble_bus}),
        .Q(in_s)
    );

    assign take = HSEL & HREADY & HTRANS[1];
    assign par = h_ff.ctrl[hbi_pkg::CTRL_PAR_BIT];

    // ****************************************
    // Bus slave and link sequencer
    // ****************************************
    always_comb
    begin
        nxt_h = h_ff;
        // Zero-wait slave: read data is ready in the data phase
        nxt_h.ap = take & HWRITE;
        if (take)
        begin
            nxt_h.aofs = HADDR[7:0];
        end
        if (take && !HWRITE)
        begin
            nxt_h.rdata = 32'h0;
            case (HADDR[7:0])
                hbi_pkg::CTRL_OFS: nxt_h.rdata[3:0] = h_ff.ctrl;
                hbi_pkg::DATA_OFS:
                    nxt_h.rdata[9:0] = {h_ff.rd, h_ff.isadr, h_ff.tbyte};
                hbi_pkg::STAT_OFS:
                begin
                    nxt_h.rdata[hbi_pkg::STAT_ACT_BIT] =
                        (h_ff.st != hbi_pkg::HST_IDLE);
                    nxt_h.rdata[hbi_pkg::STAT_BSY_BIT] = in_s[4];
                    nxt_h.rdata[hbi_pkg::STAT_RX_LSB +: 8] = h_ff.rx;
                end
                default: nxt_h.rdata = 32'h0;
            endcase
        end
        // Data-phase write; a byte write while the sequencer is not idle is dropped
        if (h_ff.ap && h_ff.aofs == hbi_pkg::CTRL_OFS)
        begin
            nxt_h.ctrl = HWDATA[3:0];
        end
        if (h_ff.ap && h_ff.aofs == hbi_pkg::DATA_OFS
            && h_ff.st == hbi_pkg::HST_IDLE)
        begin
            nxt_h.tbyte = HWDATA[7:0];
            nxt_h.isadr = HWDATA[hbi_pkg::DATA_ADR_BIT];
            nxt_h.rd = HWDATA[hbi_pkg::DATA_RD_BIT];
            nxt_h.unit = 4'h0;
            nxt_h.nunit = !par ? hbi_pkg::UNITS_SER
                : HWDATA[hbi_pkg::DATA_ADR_BIT] ? hbi_pkg::UNITS_ADR
                : hbi_pkg::UNITS_PAR;
            nxt_h.st = hbi_pkg::HST_WAIT;
        end
        unique case (h_ff.st)
            hbi_pkg::HST_IDLE:
            begin
                // Mode straps sit on the bus while deselected
                nxt_h.strb = 1'b1;
                nxt_h.hout = {1'b0, h_ff.ctrl[hbi_pkg::CTRL_CAE_BIT], par,
                    1'b0};
                nxt_h.hoe = h_ff.ctrl[hbi_pkg::CTRL_SEL_BIT] ? 4'h0 : 4'h6;
            end
            hbi_pkg::HST_WAIT:
            begin
                // Never start a byte while the device is busy
                if (in_s[4])
                begin
                    nxt_h.st = hbi_pkg::HST_HIGH;
                    nxt_h.tmr = hbi_pkg::HALF_LD;
                end
            end
            hbi_pkg::HST_HIGH:
            begin
                // Data changes mid-high, away from both strobe edges
                if (h_ff.tmr == hbi_pkg::MID_TMR && h_ff.unit != h_ff.nunit)
                begin
                    if (!par)
                    begin
                        nxt_h.hout = {3'h0, h_ff.tbyte[~h_ff.unit[2:0]]};
                        nxt_h.hoe = 4'h1;
                    end
                    else if (h_ff.isadr)
                    begin
                        nxt_h.hout = {2'h0, h_ff.tbyte[1:0]};
                        nxt_h.hoe = 4'hF;
                    end
                    else
                    begin
                        nxt_h.hout = (h_ff.unit == 4'h0) ? h_ff.tbyte[7:4]
                            : h_ff.tbyte[3:0];
                        nxt_h.hoe = h_ff.rd ? 4'h0 : 4'hF;
                    end
                end
                if (h_ff.tmr != 4'h0)
                begin
                    nxt_h.tmr = h_ff.tmr - 4'h1;
                end
                else if (h_ff.unit == h_ff.nunit)
                begin
                    nxt_h.st = hbi_pkg::HST_IDLE;
                end
                else
                begin
                    nxt_h.strb = 1'b0;
                    nxt_h.tmr = hbi_pkg::HALF_LD;
                    nxt_h.st = hbi_pkg::HST_LOW;
                end
            end
            hbi_pkg::HST_LOW:
            begin
                if (h_ff.tmr != 4'h0)
                begin
                    nxt_h.tmr = h_ff.tmr - 4'h1;
                end
                else
                begin
                    // Sample read data just before the rising edge
                    if (h_ff.rd && !h_ff.isadr)
                    begin
                        nxt_h.rx = par ? {h_ff.rx[3:0], in_s[3:0]}
                            : {h_ff.rx[6:0], in_s[3]};
                    end
                    nxt_h.strb = 1'b1;
                    nxt_h.unit = h_ff.unit + 4'h1;
                    nxt_h.tmr = hbi_pkg::HALF_LD;
                    nxt_h.st = hbi_pkg::HST_HIGH;
                end
            end
            default: nxt_h.st = hbi_pkg::HST_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            h_ff <= '{ctrl: hbi_pkg::CTRL_RST_VAL, tbyte: 8'h00,
                isadr: 1'b0, rd: 1'b0, st: hbi_pkg::HST_IDLE, tmr: 4'h0,
                unit: 4'h0, nunit: 4'h0, rx: 8'h00, strb: 1'b1,
                hout: 4'h0, hoe: 4'h0, ap: 1'b0, aofs: 8'h00,
                rdata: 32'h0};
        end
        else
        begin
            h_ff <= nxt_h;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign LNK.strobe_n = h_ff.strb;
    assign LNK.cs_n = ~h_ff.ctrl[hbi_pkg::CTRL_SEL_BIT];
    assign LNK.link_rst = h_ff.ctrl[hbi_pkg::CTRL_RST_BIT];
    assign LNK.h_out = h_ff.hout;
    assign LNK.h_oe = h_ff.hoe;
    assign HRDATA = h_ff.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
endmodule
`default_nettype wire

// ==== dv/hbi_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbi_properties (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic strobe_n,
    input wire logic cs_n,
    input wire logic link_rst,
    input wire logic [3:0] d_oe,
    input wire logic busy_oe,
    input wire logic busy_n
);
    // ********
    // Link rules
    // ********
    default clocking cb @(posedge CLK);
    endclocking
    // Only the host reset; the device reset is watched itself
    default disable iff (SYS_RST);

    // Reset releases the data lines and keeps busy high; deselect releases every device pin
    reset_drive_a: assert property (
        link_rst && $past(link_rst) |-> d_oe == 4'h0)
        else $error("Data lines driven in reset");
    reset_busy_a: assert property (
        link_rst && $past(link_rst) |-> busy_n)
        else $error("Busy low in reset");
    desel_drive_a: assert property (
        cs_n && $past(cs_n) |-> d_oe == 4'h0)
        else $error("Data lines driven while deselected");
    desel_busy_a: assert property (
        cs_n |-> !busy_oe)
        else $error("Busy driven while deselected");
    // Busy falls only at the strobe rise that ends a byte
    busy_at_rise_a: assert property (
        $fell(busy_n) |-> strobe_n && !cs_n)
        else $error("Busy fell away from a strobe rise");
    busy_min_a: assert property (
        $fell(busy_n) |-> (!busy_n) [*8])
        else $error("Busy shorter than processing");
    busy_bound_a: assert property (
        $fell(busy_n) |-> ##[9:40] $rose(busy_n))
        else $error("Busy never returned high");
    // Host must hold the strobe idle while busy
    host_wait_a: assert property (
        !busy_n |-> strobe_n)
        else $error("Strobe moved while busy");

    cover property ($fell(busy_n));
    cover property ($fell(cs_n));
    cover property ($fell(link_rst));
endmodule
`default_nettype wire

// ==== dv/tb_host_byte_interface_chip_addr.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_host_byte_interface_chip_addr;
    logic clk, sys_rst, hwrite, hreadyout, rd_mode, rx_valid;
    logic par_mode, addr_en, pm, ce, hresp;
    logic [1:0] htrans, id;
    logic [7:0] tx, rx_byte, ser, sro, par;
    logic [31:0] haddr, hwdata, hrdata;
    integer seed;
    int err_count, checks, n_stb, n_rx;

    hbi_if lnk();
    hbi_host i_hbi_host (.LNK(lnk), .CLK(clk), .SYS_RST(sys_rst),
        .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));
    hbi_dev i_hbi_dev (.LNK(lnk), .CLK(clk), .SYS_RST(lnk.link_rst),
        .CHIP_ID_BIT1(id[1]), .CHIP_ID_BIT0(id[0]), .TX_BYTE(tx),
        .READ_MODE(rd_mode), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
        .PAR_MODE(par_mode), .ADDR_EN(addr_en));
    hbi_properties i_hbi_properties (.CLK(clk), .SYS_RST(sys_rst),
        .strobe_n(lnk.strobe_n), .cs_n(lnk.cs_n), .link_rst(lnk.link_rst),
        .d_oe(lnk.d_oe), .busy_oe(lnk.busy_oe), .busy_n(lnk.busy_n));

    // ********
    // Clock, wire monitor, checks
    // ********
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Shifts in what the device samples, so bit order is seen on the wire
    always @(posedge lnk.strobe_n)
        if (lnk.cs_n === 1'b0)
        begin
            n_stb = n_stb + 1;
            ser = {ser[6:0], lnk.nibble_bus[0]};
            sro = {sro[6:0], lnk.nibble_bus[3]};
            par = {par[3:0], lnk.nibble_bus};
        end
    always @(posedge clk)
        if (rx_valid === 1'b1)
            n_rx = n_rx + 1;

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks = checks + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One single AHB transfer; read data taken at the data-phase edge
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic sel(input logic s);
        logic [31:0] q;
        // Strap copy kept by the bench, not read back from the device
        ahb(1'b1, hbi_pkg::CTRL_OFS, {28'h0, s, ce, pm, 1'b0}, q);
    endtask

    // Straps ride on the idle bus while the device reset is held
    task automatic setup(input logic p, input logic c);
        logic [31:0] q;
        pm = p;
        ce = c;
        ahb(1'b1, hbi_pkg::CTRL_OFS, {28'h1, 1'b0, c, p, 1'b1}, q);
        repeat (4) @(posedge clk);
        ahb(1'b1, hbi_pkg::CTRL_OFS, {28'h0, 1'b0, c, p, 1'b0}, q);
        repeat (4) @(posedge clk);
        chk("par_mode", {31'h0, p}, {31'h0, par_mode});
        if (!p)
            chk("addr_en", {31'h0, c}, {31'h0, addr_en});
    endtask

    // One byte or address unit; hit says whether the chip should act
    task automatic send(input logic [7:0] b, input logic adr,
        input logic rd, input logic hit);
        logic [31:0] q;
        int rx0;
        rx0 = n_rx;
        n_stb = 0;
        ahb(1'b1, hbi_pkg::DATA_OFS, {22'h0, rd, adr, b}, q);
        q = 32'h1;
        while (q[0] !== 1'b0)
            ahb(1'b0, hbi_pkg::STAT_OFS, 32'h0, q);
        repeat (4) @(posedge clk);
        chk("strobes", (adr && pm) ? 1 : (pm ? 2 : 8), 32'(n_stb));
        chk("strobe_idle", 32'h1, {31'h0, lnk.strobe_n});
        if (!adr && !rd)
        begin
            chk("wire_in", {24'h0, b}, {24'h0, pm ? par : ser});
            chk("rx_count", 32'(hit), 32'(n_rx - rx0));
            if (hit)
                chk("rx_byte", {24'h0, b}, {24'h0, rx_byte});
        end
        if (rd && hit)
        begin
            chk("wire_out", {24'h0, tx}, {24'h0, pm ? par : sro});
            ahb(1'b0, hbi_pkg::STAT_OFS, 32'h0, q);
            chk("rd_byte", {24'h0, tx}, {24'h0, q[15:8]});
        end
    endtask

    // ********
    // Main sequence: serial plain, serial addressed, parallel
    // ********
    initial
    begin
        sys_rst = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        id = 2'h0;
        tx = 8'h00;
        rd_mode = 1'b0;
        seed = 32'hB35462EA;
        {err_count, checks, n_stb, n_rx, pm, ce} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int m = 0; m < 3; m++)
        begin
            id <= (m == 1) ? 2'h2 : 2'(m);
            tx <= 8'($random(seed));
            setup(m == 2, m == 1);
            sel(1'b1);
            // Wrong address first: bytes must be ignored, busy released
            if (m != 0)
            begin
                send({6'($random(seed)), id ^ 2'h1}, 1'b1, 1'b0, 1'b0);
                send(8'($random(seed)), 1'b0, 1'b0, 1'b0);
                chk("busy_oe", 32'h0, {31'h0, lnk.busy_oe});
                sel(1'b0);
                sel(1'b1);
                send({6'($random(seed)), id}, 1'b1, 1'b0, 1'b1);
            end
            send(8'h80, 1'b0, 1'b0, 1'b1);
            send(8'h01, 1'b0, 1'b0, 1'b1);
            repeat (3)
                send(8'($random(seed)), 1'b0, 1'b0, 1'b1);
            rd_mode <= 1'b1;
            send(8'h00, 1'b0, 1'b1, 1'b1);
            // Leave read mode before deselect, so a revisit starts clean
            rd_mode <= 1'b0;
            sel(1'b0);
        end
        tally_and_finish();
    end

    // Whole run is some three thousand cycles
    initial
    begin
        #2000000;
        err_count = err_count + 1;
        $display("Watchdog expired");
        tally_and_finish();
    end
endmodule
`default_nettype wire
